// *** hw/dscs_sequencer.sv ***
module dscs_sequencer
    import dscs_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Host control
    input  wire logic        conv_trigger,
    input  wire logic        read_strobe,
    input  wire logic        chip_sel_n,
    input  wire logic        serial_cfg_in,
    // Mode straps
    input  wire logic        pseudo_mode,
    // Converter results, one per converter
    input  wire logic        cmp_a,
    input  wire logic        cmp_b,
    // Status and analog switch control
    output logic             busy_ff,
    output logic             prech_ff,
    output logic             cap_connect_ff,
    output logic [1:0]       pos_src_ff,
    output logic [1:0]       neg_src_ff,
    output logic [11:0]      result_a_ff,
    output logic [11:0]      result_b_ff,
    output logic             result_valid_ff,
    output logic [11:0]      cfg_ff
);
    dscs_state_type state_ff;
    dscs_state_type nxt_state;
    logic [3:0]     cnt_ff;
    logic           trig_d_ff;
    logic           strobe_fall_ff;
    logic           strobe_seen_ff;
    logic [3:0]     shift_cnt_ff;
    logic [11:0]    shift_ff;
    logic [3:0]     apply_cnt_ff;
    logic           applying_ff;
    logic [11:0]    sar_a_ff;
    logic [11:0]    sar_b_ff;
    logic           trig_rise;
    logic           conv_last;

    dscs_mux_if mxi ();

    ////////////////////////////////////////////////////////////////////////
    // Trigger edge and state sequence

    assign trig_rise = conv_trigger & ~trig_d_ff;
    assign conv_last = (state_ff == ST_CONV) && (cnt_ff == 4'(CONV_CYCLES - 1));

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            trig_d_ff <= 1'b0;
        else
            trig_d_ff <= conv_trigger;
    end

    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            // Count is one behind the cycles spent, so two full sampling cycles end here
            ST_ACQ:   if (trig_rise && cnt_ff >= 4'(MIN_SAMP_CYC - 1)) nxt_state = ST_HOLD;
            ST_HOLD:  nxt_state = ST_CONV;
            ST_CONV:  if (conv_last) nxt_state = ST_PRECH;
            ST_PRECH: nxt_state = ST_ACQ;
            default:  nxt_state = ST_ACQ;
        endcase
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            state_ff <= ST_ACQ;
            cnt_ff   <= 4'(MIN_SAMP_CYC);
        end
        else
        begin
            state_ff <= nxt_state;
            if (nxt_state != state_ff)
                cnt_ff <= 4'h0;
            else if (cnt_ff != 4'hf)
                cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // Busy from hold to end of conversion; low while acquiring
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            busy_ff <= 1'b0;
        else
            busy_ff <= (nxt_state == ST_HOLD) || (nxt_state == ST_CONV);
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            prech_ff <= 1'b0;
        else
            prech_ff <= (nxt_state == ST_PRECH);
    end

    ////////////////////////////////////////////////////////////////////////
    // Both converters share one bit counter so they step together

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            sar_a_ff        <= 12'h000;
            sar_b_ff        <= 12'h000;
            result_a_ff     <= 12'h000;
            result_b_ff     <= 12'h000;
            result_valid_ff <= 1'b0;
        end
        else
        begin
            result_valid_ff <= 1'b0;
            if (state_ff == ST_CONV)
            begin
                sar_a_ff <= {sar_a_ff[10:0], cmp_a};
                sar_b_ff <= {sar_b_ff[10:0], cmp_b};
                if (conv_last)
                begin
                    result_a_ff     <= {sar_a_ff[10:0], cmp_a};
                    result_b_ff     <= {sar_b_ff[10:0], cmp_b};
                    result_valid_ff <= 1'b1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration input; the falling-edge sample is modelled by
    // registering strobe and data on mclk, which the host sets up ahead.

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            strobe_fall_ff <= 1'b0;
            strobe_seen_ff <= 1'b0;
        end
        else
        begin
            strobe_fall_ff <= read_strobe & ~chip_sel_n;
            strobe_seen_ff <= strobe_fall_ff;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            shift_ff     <= CFG_RESET;
            shift_cnt_ff <= 4'h0;
        end
        else if (strobe_fall_ff && !strobe_seen_ff)
        begin
            shift_ff     <= {11'h000, serial_cfg_in};
            shift_cnt_ff <= 4'h1;
        end
        else if (shift_cnt_ff != 4'h0 && shift_cnt_ff < 4'(CFG_BITS))
        begin
            shift_ff     <= {shift_ff[10:0], serial_cfg_in};
            shift_cnt_ff <= shift_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            applying_ff  <= 1'b0;
            apply_cnt_ff <= 4'h0;
        end
        else if (strobe_fall_ff && !strobe_seen_ff)
        begin
            applying_ff  <= 1'b1;
            apply_cnt_ff <= 4'h1;
        end
        else if (applying_ff)
        begin
            apply_cnt_ff <= apply_cnt_ff + 4'h1;
            if (apply_cnt_ff == 4'(APPLY_CYCLES))
                applying_ff <= 1'b0;
        end
    end

    // Settings change only at the apply point so a half-shifted word never leaks
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cfg_ff <= CFG_RESET;
        else if (applying_ff && apply_cnt_ff == 4'(APPLY_CYCLES))
        begin
            if (shift_ff[CFG_ACT_HI:CFG_ACT_LO] == ACT_DEV_RESET)
                cfg_ff <= CFG_RESET;
            else if (shift_ff[CFG_FEAT_HI:CFG_FEAT_LO] == FEAT_UPDATE)
                cfg_ff <= shift_ff;
            else
                cfg_ff <= {shift_ff[CFG_SEL_HI_POS:CFG_SEL_LO_POS], cfg_ff[9:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input multiplexer

    assign mxi.chan_code   = cfg_ff[CFG_SEL_HI_POS:CFG_SEL_LO_POS];
    assign mxi.pseudo_mode = pseudo_mode;
    // Mux path is two flops deep, so precharge is flagged two cycles ahead
    assign mxi.prech       = (state_ff == ST_CONV) && (cnt_ff == 4'(CONV_CYCLES - 2));

    dscs_mux_sel u_mux
    (
        .mclk (mclk),
        .rst  (rst),
        .mx   (mxi.mux)
    );

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            pos_src_ff     <= SRC_IN0_POS;
            neg_src_ff     <= SRC_IN0_NEG;
            cap_connect_ff <= 1'b1;
        end
        else
        begin
            pos_src_ff     <= mxi.pos_src;
            neg_src_ff     <= mxi.neg_src;
            cap_connect_ff <= mxi.cap_connect & (nxt_state == ST_ACQ);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    sequence s_conv_run;
        (state_ff == ST_CONV) [*8] ##1 (state_ff == ST_CONV) [*4];
    endsequence

    chk_hold_to_conv: assert property (@(posedge mclk) disable iff (rst)
        state_ff == ST_HOLD |=> state_ff == ST_CONV)
        else $error("hold not followed by conversion");

    chk_conv_length: assert property (@(posedge mclk) disable iff (rst)
        $rose(state_ff == ST_CONV) |-> s_conv_run ##1 (state_ff == ST_PRECH))
        else $error("conversion not twelve cycles");

    chk_prech_one: assert property (@(posedge mclk) disable iff (rst)
        state_ff == ST_PRECH |=> state_ff == ST_ACQ)
        else $error("precharge longer than one cycle");

    chk_busy_track: assert property (@(posedge mclk) disable iff (rst)
        busy_ff == (state_ff == ST_HOLD || state_ff == ST_CONV))
        else $error("busy does not match hold and conversion");

    chk_busy_acq_low: assert property (@(posedge mclk) disable iff (rst)
        state_ff == ST_ACQ |-> !busy_ff)
        else $error("busy high during acquisition");

    chk_result_pair: assert property (@(posedge mclk) disable iff (rst)
        result_valid_ff |-> $past(state_ff == ST_CONV) && state_ff == ST_PRECH)
        else $error("results not produced together at end");

    chk_cs_gate: assert property (@(posedge mclk) disable iff (rst)
        chip_sel_n |=> !strobe_fall_ff)
        else $error("strobe acted with chip select high");

    chk_cfg_apply: assert property (@(posedge mclk) disable iff (rst)
        $changed(cfg_ff) |-> $past(applying_ff) && $past(apply_cnt_ff) == 4'(APPLY_CYCLES))
        else $error("settings changed outside apply point");

    chk_soft_reset: assert property (@(posedge mclk) disable iff (rst)
        applying_ff && apply_cnt_ff == 4'(APPLY_CYCLES)
        && shift_ff[CFG_ACT_HI:CFG_ACT_LO] == ACT_DEV_RESET |=> cfg_ff == CFG_RESET)
        else $error("software reset did not restore defaults");

    chk_min_samp: assert property (@(posedge mclk) disable iff (rst)
        $rose(state_ff == ST_ACQ) |-> (state_ff == ST_ACQ) [*2])
        else $error("sampling shorter than two cycles");
endmodule : dscs_sequencer

// *** hw/dscs_pkg.sv ***
package dscs_pkg;
    // Cycle budget of one conversion process
    localparam int unsigned CONV_CYCLES   = 12;
    localparam int unsigned PRECH_CYCLES  = 1;
    localparam int unsigned MIN_SAMP_CYC  = 2;
    localparam int unsigned MIN_PROC_CYC  = 16;
    localparam int unsigned CFG_BITS      = 12;
    localparam int unsigned APPLY_CYCLES  = 12;
    localparam int unsigned RES_BITS      = 12;
    // Clock rate and acquisition time
    localparam int unsigned CLK_MHZ       = 50;
    localparam int unsigned ACQ_TIME_PS   = 62500;
    localparam int unsigned ACQ_CYCLES    = (ACQ_TIME_PS * CLK_MHZ + 999999) / 1000000;
    // Configuration word fields
    localparam int unsigned CFG_SEL_HI_POS = 11;
    localparam int unsigned CFG_SEL_LO_POS = 10;
    localparam int unsigned CFG_FEAT_HI    = 9;
    localparam int unsigned CFG_FEAT_LO    = 8;
    localparam int unsigned CFG_FLAG_HI    = 7;
    localparam int unsigned CFG_FLAG_LO    = 3;
    localparam int unsigned CFG_ACT_HI     = 2;
    localparam int unsigned CFG_ACT_LO     = 0;
    localparam logic [11:0] CFG_RESET      = 12'h000;
    localparam logic [1:0]  FEAT_UPDATE    = 2'h1;
    localparam logic [2:0]  ACT_DEV_RESET  = 3'h5;
    // Multiplexer source codes
    localparam logic [1:0]  SRC_IN0_POS    = 2'h0;
    localparam logic [1:0]  SRC_IN1_NEG    = 2'h1;
    localparam logic [1:0]  SRC_IN1_POS    = 2'h2;
    localparam logic [1:0]  SRC_IN0_NEG    = 2'h3;
    localparam logic [1:0]  SRC_REF        = 2'h3;

    typedef enum logic [3:0]
    {
        ST_ACQ   = 4'h1,
        ST_HOLD  = 4'h2,
        ST_CONV  = 4'h4,
        ST_PRECH = 4'h8
    } dscs_state_type;
endpackage : dscs_pkg

// *** hw/dscs_mux_if.sv ***
interface dscs_mux_if;
    import dscs_pkg::*;
    logic [1:0] chan_code;
    logic       pseudo_mode;
    logic       prech;
    logic [1:0] pos_src;
    logic [1:0] neg_src;
    logic       cap_connect;
    modport ctrl (output chan_code, output pseudo_mode, output prech,
                  input pos_src, input neg_src, input cap_connect);
    modport mux  (input chan_code, input pseudo_mode, input prech,
                  output pos_src, output neg_src, output cap_connect);
endinterface : dscs_mux_if

// *** hw/dscs_mux_sel.sv ***
module dscs_mux_sel
    import dscs_pkg::*;
(
    // Clock and reset
    input  wire logic mclk,
    input  wire logic rst,
    // Mux control
    dscs_mux_if.mux   mx
);
    logic [1:0] nxt_pos;
    logic [1:0] nxt_neg;

    always_comb
    begin
        nxt_pos = SRC_IN0_POS;
        nxt_neg = SRC_IN0_NEG;
        if (mx.prech)
        begin
            nxt_pos = SRC_REF;
            nxt_neg = SRC_REF;
        end
        else if (mx.pseudo_mode)
        begin
            // Common negative is in0_neg
            unique case (mx.chan_code)
                2'h1:    nxt_pos = SRC_IN1_NEG;
                2'h2:    nxt_pos = SRC_IN1_POS;
                default: nxt_pos = SRC_IN0_POS;
            endcase
        end
        else if (mx.chan_code == 2'h3)
        begin
            nxt_pos = SRC_IN1_POS;
            nxt_neg = SRC_IN1_NEG;
        end
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mx.pos_src     <= SRC_IN0_POS;
            mx.neg_src     <= SRC_IN0_NEG;
            mx.cap_connect <= 1'b1;
        end
        else
        begin
            mx.pos_src     <= nxt_pos;
            mx.neg_src     <= nxt_neg;
            mx.cap_connect <= ~mx.prech;
        end
    end
endmodule : dscs_mux_sel

// *** verification/dscs_host_model.sv ***
module dscs_host_model (
    // Clock
    input  wire logic mclk,
    // Host controls
    output logic      conv_trigger,
    output logic      read_strobe,
    output logic      chip_sel_n,
    output logic      serial_cfg_in
);
    timeunit 1ns;
    timeprecision 1ps;

    initial
    begin
        conv_trigger  = 1'b0;
        read_strobe   = 1'b0;
        chip_sel_n    = 1'b1;
        serial_cfg_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////
    // Trigger rises mid-cycle, half a period ahead of the taking edge
    task start_conv();
        @(negedge mclk) conv_trigger <= 1'b1;
        @(negedge mclk) conv_trigger <= 1'b0;
    endtask : start_conv

    ////////////////////////////////////////////////////////////////
    task write_cfg(input logic [11:0] w, input logic sel);
        @(negedge mclk) chip_sel_n <= ~sel;
        @(negedge mclk) read_strobe <= 1'b1;
        @(negedge mclk) read_strobe <= 1'b0;
        serial_cfg_in <= w[11];
        for (int i = 10; i >= 0; i--)
        begin
            @(negedge mclk) serial_cfg_in <= w[i];
        end
        // Idle data line shows the inverse so a stale bit never passes
        @(negedge mclk) serial_cfg_in <= ~w[0];
        chip_sel_n <= 1'b1;
    endtask : write_cfg
endmodule : dscs_host_model

// *** verification/tb.sv ***
module tb;
    import dscs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic        mclk, rst, pseudo_mode, cmp_a, cmp_b, park;
    logic        conv_trigger, read_strobe, chip_sel_n, serial_cfg_in;
    logic        busy_ff, prech_ff, cap_connect_ff, result_valid_ff;
    logic [1:0]  pos_src_ff, neg_src_ff;
    logic [11:0] result_a_ff, result_b_ff, cfg_ff, cfg_model, cfg_seen;
    logic [23:0] res_q[$];
    logic [11:0] cfg_q[$];
    logic [7:0]  rnd;
    logic [11:0] w;
    logic [2:0]  mux_tab[5] = '{3'b011, 3'b000, 3'b101, 3'b110, 3'b100};
    int          mismatches, n_checks;

    dscs_host_model i_host (.mclk(mclk), .conv_trigger(conv_trigger), .read_strobe(read_strobe),
                            .chip_sel_n(chip_sel_n), .serial_cfg_in(serial_cfg_in));
    dscs_sequencer i_dut (.mclk(mclk), .rst(rst), .conv_trigger(conv_trigger), .read_strobe(read_strobe),
                          .chip_sel_n(chip_sel_n), .serial_cfg_in(serial_cfg_in), .pseudo_mode(pseudo_mode),
                          .cmp_a(cmp_a), .cmp_b(cmp_b), .busy_ff(busy_ff), .prech_ff(prech_ff),
                          .cap_connect_ff(cap_connect_ff), .pos_src_ff(pos_src_ff), .neg_src_ff(neg_src_ff),
                          .result_a_ff(result_a_ff), .result_b_ff(result_b_ff),
                          .result_valid_ff(result_valid_ff), .cfg_ff(cfg_ff));

    initial mclk = 1'b0;
    // Parking holds the clock low so stopped-clock retention is exercised
    always #10 mclk = park ? 1'b0 : ~mclk;

    ////////////////////////////////////////////////////////////////
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : lfsr_next

    function automatic logic [11:0] next_cfg(input logic [11:0] o, input logic [11:0] nw);
        if (nw[CFG_ACT_HI:CFG_ACT_LO] == ACT_DEV_RESET)
            return CFG_RESET;
        if (nw[CFG_FEAT_HI:CFG_FEAT_LO] == FEAT_UPDATE)
            return nw;
        return {nw[CFG_SEL_HI_POS:CFG_SEL_LO_POS], o[9:0]};
    endfunction : next_cfg

    function automatic logic [3:0] exp_src(input logic [1:0] code);
        case (code)
            2'h0:    return {SRC_IN0_POS, SRC_IN0_NEG};
            2'h1:    return {SRC_IN1_NEG, SRC_IN0_NEG};
            2'h2:    return {SRC_IN1_POS, SRC_IN0_NEG};
            default: return {SRC_IN1_POS, SRC_IN1_NEG};
        endcase
    endfunction : exp_src

    task report_and_stop();
        if (mismatches == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop

    task park_clock();
        @(negedge mclk);
        park = 1'b1;
        #205;
        park = 1'b0;
        @(posedge mclk) #1;
    endtask : park_clock

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    ////////////////////////////////////////////////////////////////
    task wr(input logic [11:0] nw, input logic sel);
        logic [11:0] nx;
        nx = sel ? next_cfg(cfg_model, nw) : cfg_model;
        if (nx !== cfg_model)
            cfg_q.push_back(nx);
        i_host.write_cfg(nw, sel);
        check(cfg_ff, cfg_model);
        @(posedge mclk) #1;
        check(cfg_ff, nx);
        cfg_model = nx;
    endtask : wr

    task conv(input logic a, input logic b);
        int n;
        n = 0;
        while ((busy_ff !== 1'b0 || prech_ff !== 1'b0) && n < 40)
        begin
            @(posedge mclk) #1;
            n++;
        end
        check(n < 40, 1);
        if (n >= 40)
            report_and_stop();
        // Two acquisition cycles at least before the next trigger
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        cmp_a = a;
        cmp_b = b;
        res_q.push_back({{12{a}}, {12{b}}});
        i_host.start_conv();
        @(posedge mclk) #1;
        check({busy_ff, cap_connect_ff}, 2'b10);
        n = 1;
        while (busy_ff === 1'b1 && n < 20)
        begin
            @(posedge mclk) #1;
            n++;
        end
        check(n, CONV_CYCLES + 1);
        if (n >= 20)
            report_and_stop();
        check({prech_ff, cap_connect_ff, pos_src_ff, neg_src_ff}, {2'b10, SRC_REF, SRC_REF});
        @(posedge mclk) #1;
        check({prech_ff, cap_connect_ff, busy_ff}, 3'b010);
    endtask : conv

    ////////////////////////////////////////////////////////////////
    // Scoreboard: results and applied words against the oldest note
    always @(posedge mclk)
    begin
        #1;
        if (result_valid_ff === 1'b1)
        begin
            if (res_q.size() == 0)
                check(1, 0);
            else
                check({result_a_ff, result_b_ff}, res_q.pop_front());
        end
        if (cfg_ff !== cfg_seen)
        begin
            if (cfg_q.size() == 0)
                check(cfg_ff, cfg_seen);
            else
                check(cfg_ff, cfg_q.pop_front());
            cfg_seen = cfg_ff;
        end
    end

    initial
    begin
        #1500000;
        mismatches++;
        report_and_stop();
    end

    initial
    begin
        rst         = 1'b1;
        pseudo_mode = 1'b0;
        park        = 1'b0;
        cmp_a       = 1'b0;
        cmp_b       = 1'b0;
        mismatches  = 0;
        n_checks    = 0;
        rnd         = 8'h5e;
        cfg_model   = CFG_RESET;
        cfg_seen    = CFG_RESET;
        repeat (4) @(posedge mclk);
        @(negedge mclk) rst = 1'b0;
        check({cfg_ff, busy_ff, cap_connect_ff}, {CFG_RESET, 2'b01});
        for (int i = 0; i < 5; i++)
        begin
            @(negedge mclk);
            pseudo_mode = mux_tab[i][2];
            wr({mux_tab[i][1:0], 10'h000}, 1'b1);
            repeat (2) @(posedge mclk) #1;
            check({pos_src_ff, neg_src_ff}, exp_src(mux_tab[i][1:0]));
        end
        for (int i = 0; i < 12; i++)
        begin
            rnd = lfsr_next(rnd);
            if (i % 2 == 0)
                conv(rnd[0], rnd[3]);
            else
            begin
                w = {rnd, rnd[7:4] ^ rnd[3:0]};
                if (w[9:8] == 2'h2)
                    w[9:8] = FEAT_UPDATE;
                if (w[2:0] == ACT_DEV_RESET)
                    w[2:0] = 3'h0;
                wr(w, 1'b1);
            end
        end
        wr(12'hd78, 1'b1);
        wr(12'hd7d, 1'b1);
        wr(12'h5f8, 1'b0);
        wr(12'h9f9, 1'b1);
        park_clock();
        check(cfg_ff, 12'h9f9);
        cfg_q.push_back(CFG_RESET);
        @(negedge mclk) rst = 1'b1;
        @(negedge mclk) rst = 1'b0;
        check(cfg_ff, CFG_RESET);
        cfg_model = CFG_RESET;
        conv(1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        park_clock();
        check({result_a_ff, result_b_ff, busy_ff, cap_connect_ff}, {24'hfff000, 2'b01});
        repeat (5) @(posedge mclk);
        report_and_stop();
    end
endmodule : tb
